// file: core/somf_pkg.sv
`default_nettype none
package somf_pkg;

    localparam int CLK_FREQ_HZ = 40_000_000;
    localparam int RST_DELAY_NS = 10_000;
    localparam int RST_DELAY_CYCLES = (RST_DELAY_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
    localparam int LONG_WIN_MS = 200;
    localparam int LONG_WIN_CYCLES_DEF = LONG_WIN_MS * (CLK_FREQ_HZ / 1000);
    localparam int LW_CNT_W = 24;
    localparam int RD_CNT_W = 16;

    localparam int NWK = 3;
    localparam int P_CSN = 0;
    localparam int P_SCLK = 1;
    localparam int P_MOSI = 2;
    localparam int P_CAN = 3;
    localparam int P_LIN = 4;
    localparam int P_DBG = 5;
    localparam int P_CFG = 6;
    localparam int P_WK = 7;
    localparam int NPIN = P_WK + NWK;
    // Idle levels of the pins: frame select high and debug strap released.
    localparam logic [NPIN-1:0] PIN_IDLE = NPIN'((1 << P_CSN) | (1 << P_DBG));

    localparam int FRAME_BITS = 16;
    localparam logic [4:0] FRAME_LEN = 5'h10;
    localparam logic [6:0] MODE_CTRL_ADDR = 7'h01;
    localparam logic [6:0] WD_CTRL_ADDR = 7'h03;
    localparam int WR_BIT = 15;
    localparam int ADDR_LSB = 8;
    localparam int MODE_LSB = 6;

    typedef enum logic [1:0] {
        SEL_NORMAL = 2'h0,
        SEL_SLEEP = 2'h1,
        SEL_STOP = 2'h2,
        SEL_RESET = 2'h3
    } somf_sel_t;

    typedef enum logic [2:0] {
        ST_INIT = 3'h0,
        ST_NORMAL = 3'h1,
        ST_STOP = 3'h3,
        ST_SLEEP = 3'h2,
        ST_RESTART = 3'h6,
        ST_FAILSAFE = 3'h4
    } somf_state_t;

    typedef struct packed {
        somf_state_t st;
        logic [NPIN-1:0] sy1;
        logic [NPIN-1:0] sy2;
        logic [NPIN-1:0] sy3;
        logic [NPIN-1:0] flt;
        logic dbg;
        logic cfg;
        logic ot;
        somf_sel_t mode_sel;
        logic [4:0] bit_cnt;
        logic [FRAME_BITS-1:0] rx;
        logic [FRAME_BITS-1:0] tx;
        logic lw_run;
        logic [LW_CNT_W-1:0] lw_cnt;
        logic [RD_CNT_W-1:0] rd_cnt;
        logic reg_en;
        logic mcu_rst_n;
        logic wake_irq;
        logic wd_stop;
        logic miso;
        logic [2:0] mode_out;
    } somf_q_t;

endpackage : somf_pkg
`default_nettype wire

// file: core/somf_top.sv
`default_nettype none
module somf_top
    import somf_pkg::*;
#(
    parameter int LONG_WIN_CYCLES = LONG_WIN_CYCLES_DEF
)(
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic SPI_CSN,
    input wire logic SPI_SCLK,
    input wire logic SPI_MOSI,
    output logic SPI_MISO,
    input wire logic WAKE_CAN,
    input wire logic WAKE_LIN,
    input wire logic [NWK-1:0] WAKE_INPUTS,
    input wire logic DEBUG_STRAP,
    input wire logic CFG_STRAP,
    input wire logic WD_FAIL,
    input wire logic UV_RESET,
    input wire logic OVERTEMP,
    output logic MAIN_REG_EN,
    output logic MCU_RESET_N,
    output logic WAKE_IRQ,
    output logic WD_STOP,
    output logic [2:0] MODE
);

    localparam logic [LW_CNT_W-1:0] LW_LAST = LW_CNT_W'(LONG_WIN_CYCLES - 1);
    localparam logic [RD_CNT_W-1:0] RD_LAST = RD_CNT_W'(RST_DELAY_CYCLES - 1);

    // Pin stages start idle, so release gives no false select or strap edge.
    // The long open window runs from the release of reset.
    localparam somf_q_t Q_RST = '{
        st: ST_INIT,
        sy1: PIN_IDLE,
        sy2: PIN_IDLE,
        sy3: PIN_IDLE,
        flt: PIN_IDLE,
        dbg: 1'b0,
        cfg: 1'b0,
        ot: 1'b0,
        mode_sel: SEL_NORMAL,
        bit_cnt: 5'h00,
        rx: '0,
        tx: '0,
        lw_run: 1'b1,
        lw_cnt: '0,
        rd_cnt: '0,
        reg_en: 1'b0,
        mcu_rst_n: 1'b0,
        wake_irq: 1'b0,
        wd_stop: 1'b0,
        miso: 1'b0,
        mode_out: 3'h0
    };

    somf_q_t q;
    somf_q_t n;

    ////////////////////////////////////////////////////////////////////////////////

    logic [NPIN-1:0] pins;
    logic csn_fall;
    logic csn_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic frame_ok;
    logic mode_wr;
    logic wd_trig;
    logic wake;
    logic [NWK+1:0] wake_now;
    logic [NWK+1:0] wake_was;
    logic rx_write;
    logic [WR_BIT-ADDR_LSB-1:0] rx_addr;
    logic lw_expire;
    logic wd_fail_ev;
    logic ot_clear;
    somf_sel_t req;
    somf_state_t fail_tgt;

    assign pins = {WAKE_INPUTS, CFG_STRAP, DEBUG_STRAP, WAKE_LIN, WAKE_CAN,
                   SPI_MOSI, SPI_SCLK, SPI_CSN};

    ////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        n = q;
        n.wake_irq = 1'b0;

        // Three-stage capture; a level is taken once the last two stages agree.
        n.sy1 = pins;
        n.sy2 = q.sy1;
        n.sy3 = q.sy2;
        n.flt = (q.sy2 & q.sy3) | (q.flt & (q.sy2 ^ q.sy3));

        csn_fall = q.flt[P_CSN] & ~n.flt[P_CSN];
        csn_rise = ~q.flt[P_CSN] & n.flt[P_CSN];
        sclk_rise = ~q.flt[P_SCLK] & n.flt[P_SCLK];
        sclk_fall = q.flt[P_SCLK] & ~n.flt[P_SCLK];

        // Serial frame: shift in on rising clock, shift out on falling clock.
        if (csn_fall)
        begin
            n.bit_cnt = 5'h00;
            n.tx = {q.mode_sel, 3'(q.st), 11'h000};
            n.miso = q.mode_sel[1];
        end
        else if (!q.flt[P_CSN] && sclk_rise)
        begin
            n.rx = {q.rx[FRAME_BITS-2:0], n.flt[P_MOSI]};
            if (q.bit_cnt <= FRAME_LEN)
            begin
                n.bit_cnt = q.bit_cnt + 5'h01;
            end
        end
        else if (!q.flt[P_CSN] && sclk_fall)
        begin
            n.tx = {q.tx[FRAME_BITS-2:0], 1'b0};
            n.miso = q.tx[FRAME_BITS-2];
        end

        frame_ok = csn_rise && (q.bit_cnt == FRAME_LEN);
        rx_write = q.rx[WR_BIT];
        rx_addr = q.rx[WR_BIT-1:ADDR_LSB];
        mode_wr = frame_ok && rx_write && (rx_addr == MODE_CTRL_ADDR);
        wd_trig = frame_ok && rx_write && (rx_addr == WD_CTRL_ADDR);
        req = somf_sel_t'(q.rx[MODE_LSB+1:MODE_LSB]);

        // Rising edges of the wake sources; the two strap pins are left out.
        wake_now = {n.flt[NPIN-1:P_WK], n.flt[P_LIN:P_CAN]};
        wake_was = {q.flt[NPIN-1:P_WK], q.flt[P_LIN:P_CAN]};
        wake = |(wake_now & ~wake_was);

        // Long open window; stopped while debug mode is active.
        lw_expire = 1'b0;
        if (wd_trig)
        begin
            n.lw_run = 1'b0;
            n.lw_cnt = '0;
        end
        else if (q.lw_run && !q.dbg)
        begin
            if (q.lw_cnt == LW_LAST)
            begin
                lw_expire = 1'b1;
                n.lw_run = 1'b0;
                n.lw_cnt = '0;
            end
            else
            begin
                n.lw_cnt = q.lw_cnt + 1'b1;
            end
        end

        wd_fail_ev = lw_expire || (WD_FAIL && !q.dbg);
        fail_tgt = q.cfg ? ST_RESTART : ST_FAILSAFE;
        n.ot = OVERTEMP;
        ot_clear = q.ot && !OVERTEMP;

        ////////////////////////////////////////////////////////////////////////////

        case (q.st)
            ST_INIT:
            begin
                if (!q.flt[P_DBG])
                begin
                    n.dbg = 1'b1;
                end
                n.cfg = q.flt[P_CFG];
                if (frame_ok)
                begin
                    n.st = ST_NORMAL;
                end
                // Wake events are not looked at here.
            end
            ST_NORMAL:
            begin
                if (wake)
                begin
                    n.wake_irq = 1'b1;
                end
                if (mode_wr)
                begin
                    case (req)
                        SEL_STOP:
                        begin
                            n.st = ST_STOP;
                            n.mode_sel = SEL_STOP;
                        end
                        SEL_SLEEP:
                        begin
                            n.st = ST_SLEEP;
                            n.mode_sel = SEL_SLEEP;
                        end
                        SEL_RESET:
                        begin
                            n.st = ST_INIT;
                            n.mode_sel = SEL_NORMAL;
                        end
                        default:
                        begin
                            n.mode_sel = SEL_NORMAL;
                        end
                    endcase
                end
            end
            ST_STOP:
            begin
                if (wake)
                begin
                    n.wake_irq = 1'b1;
                end
                if (mode_wr && req == SEL_NORMAL)
                begin
                    n.st = ST_NORMAL;
                    n.mode_sel = SEL_NORMAL;
                end
                else if (mode_wr && req == SEL_RESET)
                begin
                    n.st = ST_INIT;
                    n.mode_sel = SEL_NORMAL;
                end
            end
            ST_SLEEP:
            begin
                if (wake)
                begin
                    n.st = ST_RESTART;
                end
            end
            ST_RESTART:
            begin
                n.mode_sel = SEL_NORMAL;
                if (UV_RESET)
                begin
                    n.rd_cnt = '0;
                end
                else if (q.rd_cnt == RD_LAST)
                begin
                    n.rd_cnt = '0;
                    n.st = ST_NORMAL;
                end
                else
                begin
                    n.rd_cnt = q.rd_cnt + 1'b1;
                end
            end
            ST_FAILSAFE:
            begin
                if (wake || ot_clear)
                begin
                    n.st = ST_RESTART;
                end
            end
            default:
            begin
                n.st = ST_INIT;
            end
        endcase

        // Failures seen while the regulator is up and the part is not resetting.
        if (q.st == ST_INIT || q.st == ST_NORMAL || q.st == ST_STOP)
        begin
            if (OVERTEMP && !q.ot)
            begin
                n.st = ST_FAILSAFE;
            end
            else if (wd_fail_ev)
            begin
                n.st = fail_tgt;
            end
            else if (UV_RESET)
            begin
                n.st = ST_RESTART;
            end
        end

        // The long window starts again on entry to init and on leaving restart.
        if (n.st != q.st && (n.st == ST_INIT || q.st == ST_RESTART))
        begin
            n.lw_run = 1'b1;
            n.lw_cnt = '0;
        end
        // Restart clears the mode field on entry and for as long as it lasts.
        if (n.st == ST_RESTART)
        begin
            n.rd_cnt = (q.st == ST_RESTART) ? n.rd_cnt : '0;
            n.mode_sel = SEL_NORMAL;
        end

        n.reg_en = !(n.st == ST_SLEEP || n.st == ST_FAILSAFE);
        n.mcu_rst_n = (n.st != ST_RESTART);
        n.wd_stop = n.dbg;
        n.mode_out = 3'(n.st);
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge CORE_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            q <= Q_RST;
        end
        else
        begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    // Every output is taken straight from the state register.
    assign SPI_MISO = q.miso;
    assign MAIN_REG_EN = q.reg_en;
    assign MCU_RESET_N = q.mcu_rst_n;
    assign WAKE_IRQ = q.wake_irq;
    assign WD_STOP = q.wd_stop;
    assign MODE = q.mode_out;

endmodule : somf_top
`default_nettype wire

// file: tb/somf_properties.sv
`default_nettype none
module somf_properties
    import somf_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic MAIN_REG_EN,
    input wire logic MCU_RESET_N,
    input wire logic WAKE_IRQ,
    input wire logic WD_STOP,
    input wire logic [2:0] MODE
);
    logic [RD_CNT_W-1:0] rs_cnt_ff;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    ////////////////////////////////////////////////////////////
    // Counts the cycles spent in restart.
    always_ff @(posedge CORE_CLK or negedge RESETN)
        if (!RESETN)
            rs_cnt_ff <= '0;
        else
            rs_cnt_ff <= (MODE == ST_RESTART) ? rs_cnt_ff + 1'b1 : '0;
    a_mode_legal: assert property (MODE inside {ST_INIT, ST_NORMAL, ST_STOP, ST_SLEEP,
        ST_RESTART, ST_FAILSAFE}) else $error("mode code illegal");
    a_stop_reg_on: assert property (MODE == ST_STOP |-> MAIN_REG_EN)
        else $error("regulator off in stop");
    a_sleep_reg_off: assert property (MODE == ST_SLEEP |-> !MAIN_REG_EN)
        else $error("regulator on in sleep");
    a_failsafe_reg_off: assert property (MODE == ST_FAILSAFE |-> !MAIN_REG_EN)
        else $error("regulator on in fail-safe");
    a_restart_holds_reset: assert property (MODE == ST_RESTART |-> !MCU_RESET_N)
        else $error("controller reset released in restart");
    a_wake_exit_restart: assert property ($past(MODE) inside {ST_SLEEP, ST_FAILSAFE}
        && MODE != $past(MODE) |-> MODE == ST_RESTART) else $error("bad exit from low mode");
    a_restart_to_normal: assert property ($past(MODE) == ST_RESTART && MODE != ST_RESTART
        |-> MODE == ST_NORMAL && rs_cnt_ff >= RST_DELAY_CYCLES - 1)
        else $error("restart left early or to wrong mode");
    a_low_power_entry: assert property (MODE inside {ST_STOP, ST_SLEEP}
        && $past(MODE) != MODE |-> $past(MODE) == ST_NORMAL)
        else $error("low power mode entered from wrong mode");
    a_irq_awake_only: assert property (WAKE_IRQ |-> MODE inside {ST_NORMAL, ST_STOP}
        && $stable(MODE) ##1 !WAKE_IRQ) else $error("wake interrupt misplaced");
    a_init_exit: assert property ($past(MODE) == ST_INIT && MODE != ST_INIT
        |-> MODE inside {ST_NORMAL, ST_RESTART, ST_FAILSAFE}) else $error("bad exit from init");
    a_debug_sticky: assert property (MODE != ST_INIT && $past(MODE) != ST_INIT
        |-> $stable(WD_STOP)) else $error("debug mode changed outside init");
endmodule : somf_properties
bind somf_top somf_properties u_props (
    .CORE_CLK(CORE_CLK),
    .RESETN(RESETN),
    .MAIN_REG_EN(MAIN_REG_EN),
    .MCU_RESET_N(MCU_RESET_N),
    .WAKE_IRQ(WAKE_IRQ),
    .WD_STOP(WD_STOP),
    .MODE(MODE)
);
`default_nettype wire

// file: tb/somf_host.sv
`default_nettype none
module somf_host (
    input wire logic clk,
    input wire logic miso,
    output var logic csn,
    output var logic sclk,
    output var logic mosi
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        csn = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    // Sends n bits of w, first bit first, h core cycles per clock phase.
    task automatic frame(input logic [15:0] w, input int n, input int h, output logic [15:0] r);
        r = '0;
        csn <= 1'b0;
        for (int i = 0; i < n; i++)
        begin
            mosi <= w[15 - i];
            repeat (h) @(posedge clk);
            sclk <= 1'b1;
            repeat (h) @(posedge clk);
            // Taken while the clock is high, once the answer has settled.
            r = {r[14:0], miso};
            sclk <= 1'b0;
        end
        repeat (h) @(posedge clk);
        csn <= 1'b1;
        mosi <= ~mosi;
        repeat (8) @(posedge clk);
    endtask : frame
endmodule : somf_host
`default_nettype wire

// file: tb/somf_top_tb.sv
`default_nettype none
module somf_top_tb
    import somf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LW = 2000;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic debug_strap = 1'b1;
    logic cfg_strap = 1'b1;
    logic wd_fail = 1'b0;
    logic uv_reset = 1'b0;
    logic overtemp = 1'b0;
    logic [4:0] wk = 5'h00;
    logic spi_csn, spi_sclk, spi_mosi, spi_miso, main_reg_en, mcu_reset_n, wake_irq, wd_stop;
    logic [2:0] mode;
    logic [15:0] rx;
    int bad_count = 0;
    int samples_checked = 0;
    int irq_seen = 0;
    int cyc = 0;
    always #12.5 core_clk = ~core_clk;
    somf_top #(.LONG_WIN_CYCLES(LW)) dut (
        .CORE_CLK(core_clk),
        .RESETN(resetn),
        .SPI_CSN(spi_csn),
        .SPI_SCLK(spi_sclk),
        .SPI_MOSI(spi_mosi),
        .SPI_MISO(spi_miso),
        .WAKE_CAN(wk[0]),
        .WAKE_LIN(wk[1]),
        .WAKE_INPUTS(wk[4:2]),
        .DEBUG_STRAP(debug_strap),
        .CFG_STRAP(cfg_strap),
        .WD_FAIL(wd_fail),
        .UV_RESET(uv_reset),
        .OVERTEMP(overtemp),
        .MAIN_REG_EN(main_reg_en),
        .MCU_RESET_N(mcu_reset_n),
        .WAKE_IRQ(wake_irq),
        .WD_STOP(wd_stop),
        .MODE(mode)
    );
    somf_host host (
        .clk(core_clk),
        .miso(spi_miso),
        .csn(spi_csn),
        .sclk(spi_sclk),
        .mosi(spi_mosi)
    );
    ////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        irq_seen <= irq_seen + int'(wake_irq === 1'b1);
        if (cyc == 60000)
        begin
            bad_count++;
            end_sim();
        end
    end
    task automatic chk(input logic [2:0] s, input logic [2:0] e);
        samples_checked++;
        if (s !== e)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick
    task automatic wait_mode(input logic [2:0] m, input int n);
        for (int i = 0; i < n && mode !== m; i++)
            @(posedge core_clk);
    endtask : wait_mode
    task automatic rst(input logic strap);
        resetn <= 1'b0;
        debug_strap <= strap;
        tick(3);
        resetn <= 1'b1;
        tick(6);
    endtask : rst
    task automatic req(input somf_sel_t s);
        host.frame({1'b1, MODE_CTRL_ADDR, s, 6'h00}, 16, 4, rx);
    endtask : req
    task automatic trig();
        host.frame({1'b1, WD_CTRL_ADDR, 8'h5a}, 16, 6, rx);
    endtask : trig
    task automatic wake(input int i);
        wk <= 5'(1 << i);
        tick(8);
        wk <= 5'h00;
        tick(8);
    endtask : wake
    task automatic pulse_wd();
        wd_fail <= 1'b1;
        tick(1);
        wd_fail <= 1'b0;
        tick(4);
    endtask : pulse_wd
    task automatic to_normal();
        wait_mode(ST_NORMAL, 500);
        chk(mode, ST_NORMAL);
        trig();
    endtask : to_normal
    ////////////////////////////////////////////////////////////
    task automatic sc_init();
        chk(mode, ST_INIT);
        chk(3'(main_reg_en & mcu_reset_n), 3'h1);
        wake(0);
        chk(mode, ST_INIT);
        chk(3'(irq_seen), 3'h0);
        host.frame(16'h7f00, 15, 4, rx);
        chk(mode, ST_INIT);
        host.frame(16'h7fff, 16, 4, rx);
        chk(mode, ST_NORMAL);
        trig();
    endtask : sc_init
    task automatic sc_modes();
        int b;
        b = irq_seen;
        for (int i = 0; i < 5; i++)
            wake(i);
        chk(3'(irq_seen - b), 3'h5);
        chk(mode, ST_NORMAL);
        req(SEL_STOP);
        chk(mode, ST_STOP);
        chk(3'(main_reg_en), 3'h1);
        req(SEL_SLEEP);
        chk(mode, ST_STOP);
        req(SEL_NORMAL);
        req(SEL_SLEEP);
        chk(mode, ST_SLEEP);
        chk(3'(main_reg_en), 3'h0);
        wake(1);
        chk(mode, ST_RESTART);
        chk(3'(mcu_reset_n), 3'h0);
        tick(380);
        chk(mode, ST_RESTART);
        to_normal();
        host.frame({1'b0, MODE_CTRL_ADDR, 8'h00}, 16, 4, rx);
        chk(3'(rx[15:14]), 3'(SEL_NORMAL));
    endtask : sc_modes
    task automatic sc_faults();
        uv_reset <= 1'b1;
        tick(520);
        chk(mode, ST_RESTART);
        uv_reset <= 1'b0;
        tick(380);
        chk(mode, ST_RESTART);
        to_normal();
        cfg_strap <= 1'b0;
        req(SEL_RESET);
        chk(mode, ST_INIT);
        trig();
        pulse_wd();
        chk(mode, ST_FAILSAFE);
        chk(3'(main_reg_en), 3'h0);
        req(SEL_NORMAL);
        chk(mode, ST_FAILSAFE);
        wake(4);
        chk(mode, ST_RESTART);
        cfg_strap <= 1'b1;
        to_normal();
        overtemp <= 1'b1;
        tick(60);
        chk(mode, ST_FAILSAFE);
        overtemp <= 1'b0;
        tick(6);
        chk(mode, ST_RESTART);
        to_normal();
        req(SEL_RESET);
        tick(LW - 100);
        chk(mode, ST_INIT);
        wait_mode(ST_RESTART, 200);
        chk(mode, ST_RESTART);
        to_normal();
    endtask : sc_faults
    task automatic sc_debug();
        rst(1'b0);
        tick(LW + 100);
        chk(3'(wd_stop), 3'h1);
        chk(mode, ST_INIT);
        trig();
        pulse_wd();
        chk(mode, ST_NORMAL);
        req(SEL_STOP);
        chk(mode, ST_STOP);
    endtask : sc_debug
    initial
    begin
        rst(1'b1);
        sc_init();
        sc_modes();
        sc_faults();
        sc_debug();
        end_sim();
    end
endmodule : somf_top_tb
`default_nettype wire
